// ==== core/mdf_pkg.sv ====
// constants, state encoding and carrier types for the multiply, divide and
// floating point datapath; assumes one processor clock and the sign-and-
// coefficient word layout chosen below for floating operands.
//
// Functional notes
// - single multiply uses upper accumulator and operand
// - single product high half lower, low half upper
// - single divide: quotient upper, remainder lower accumulator
// - single quotient overflow aborts, flags divide fault
// - double multiply gives 96-bit product across three
// - extension gets low 48, double accumulator high
// - two-word operand: upper at address, lower next
// - double divide: 96 by 48, quotient in pair
// - extension supplies low dividend, receives remainder
// - double quotient overflow aborts, flags divide fault
// - switch off traps double and floating operations
// - floating add gives rounded normalized sum
// - floating subtract gives rounded normalized difference
// - alignment spill into extension top, 63 max
// - exponent beyond plus minus 1023 faults
// - floating multiply gives rounded normalized product
// - low 36 product bits into extension 47:12
// - floating divide: quotient pair, remainder extension
// - floating remainder carries dividend sign
// - unnormalized floating divisor raises divide fault
`default_nettype none
package mdf_pkg;
    ////////////////////////////////////////////////////////////////////////
    // opcodes, octal 50 51 56 57 60 61 62 63
    localparam logic [5:0] MDF_OP_MUL_S = 6'h28;
    localparam logic [5:0] MDF_OP_DIV_S = 6'h29;
    localparam logic [5:0] MDF_OP_MUL_D = 6'h2E;
    localparam logic [5:0] MDF_OP_DIV_D = 6'h2F;
    localparam logic [5:0] MDF_OP_FADD  = 6'h30;
    localparam logic [5:0] MDF_OP_FSUB  = 6'h31;
    localparam logic [5:0] MDF_OP_FMUL  = 6'h32;
    localparam logic [5:0] MDF_OP_FDIV  = 6'h33;
    // floating word: sign 47, biased exponent 46:36, coefficient 35:0
    localparam int                 MDF_F_SIGN  = 47;
    localparam int                 MDF_F_EXPHI = 46;
    localparam int                 MDF_F_EXPLO = 36;
    localparam logic signed [13:0] MDF_EXP_BIAS = 14'sh0400;
    localparam logic signed [13:0] MDF_EXP_LIM  = 14'sh03FF;
    localparam logic [13:0]        MDF_ALIGN_MAX = 14'h003F;
    // quotient magnitude limits, 23 and 47 bits
    localparam logic signed [47:0] MDF_QS_MAX = 48'sh0000007FFFFF;
    localparam logic signed [95:0] MDF_QD_MAX = 96'sh000000000000_7FFFFFFFFFFF;
    localparam logic [23:0]        MDF_ACC_RST = 24'h000000;
    localparam logic [47:0]        MDF_EXT_RST = 48'h000000000000;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {MDF_IDLE, MDF_HI, MDF_LO, MDF_EXEC} mdf_state_t;
    typedef struct packed {
        logic [5:0]  opcode;
        logic [14:0] addr;
    } mdf_req_t;
    typedef struct packed {
        logic [23:0] a;
        logic [23:0] q;
        logic [47:0] e;
    } mdf_acc_t;
endpackage
`default_nettype wire

// ==== core/mdf_unit.sv ====
// multiply, divide and floating point datapath with its accumulators
// assumes the instruction control forms the effective address and holds
// start for one cycle; storage answers on this clock with mem_ack.
`default_nettype none
module mdf_unit (
    input  wire logic           sys_clk,
    input  wire logic           sys_rst,
    input  wire logic           start,
    input  wire mdf_pkg::mdf_req_t req,
    input  wire logic           float_enable_switch,
    input  wire logic           acc_wr,
    input  wire mdf_pkg::mdf_acc_t acc_in,
    output var  logic           mem_req,
    output var  logic [14:0]    mem_addr,
    input  wire logic           mem_ack,
    input  wire logic [23:0]    mem_rdata,
    output var  mdf_pkg::mdf_acc_t acc,
    output var  logic           done,
    output var  logic           trap,
    output var  logic           divide_fault,
    output var  logic           exp_fault
);
    ////////////////////////////////////////////////////////////////////////
    mdf_pkg::mdf_state_t state;
    logic [5:0]  cmd;
    logic [23:0] op_hi;
    logic [23:0] op_lo;
    logic        sw_s1;
    logic        sw_s2;

    // switch is a console pin: two flops before use
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_s1 <= 1'b0;
            sw_s2 <= 1'b0;
        end else begin
            sw_s1 <= float_enable_switch;
            sw_s2 <= sw_s1;
        end
    end

    // opcode decode
    wire is_two  = (req.opcode >= mdf_pkg::MDF_OP_MUL_D) && (req.opcode <= mdf_pkg::MDF_OP_FDIV);
    wire is_one  = (req.opcode == mdf_pkg::MDF_OP_MUL_S) || (req.opcode == mdf_pkg::MDF_OP_DIV_S);
    wire do_trap = start && is_two && !sw_s2;
    wire do_go   = start && (is_one || (is_two && sw_s2));
    wire cmd_two = (cmd >= mdf_pkg::MDF_OP_MUL_D);

    ////////////////////////////////////////////////////////////////////////
    // fixed point results
    wire signed [47:0] mu_p  = $signed(acc.a) * $signed(op_hi);
    wire signed [47:0] dv_n  = $signed({acc.a, acc.q});
    wire               dv_z  = (op_hi == 24'h000000);
    wire signed [47:0] dv_d  = dv_z ? 48'sh000000000001 : 48'($signed(op_hi));
    wire signed [47:0] dv_q  = dv_n / dv_d;
    wire signed [47:0] dv_r  = dv_n % dv_d;
    wire               dv_f  = dv_z || (dv_q > mdf_pkg::MDF_QS_MAX) || (dv_q < -mdf_pkg::MDF_QS_MAX);
    wire signed [95:0] md_p  = $signed({acc.a, acc.q}) * $signed({op_hi, op_lo});
    wire signed [95:0] dd_n  = $signed({acc.a, acc.q, acc.e});
    wire               dd_z  = ({op_hi, op_lo} == 48'h000000000000);
    wire signed [95:0] dd_d  = dd_z ? 96'sh1 : 96'($signed({op_hi, op_lo}));
    wire signed [95:0] dd_q  = dd_n / dd_d;
    wire signed [95:0] dd_r  = dd_n % dd_d;
    wire               dd_f  = dd_z || (dd_q > mdf_pkg::MDF_QD_MAX) || (dd_q < -mdf_pkg::MDF_QD_MAX);

    ////////////////////////////////////////////////////////////////////////
    // normalise, round half up on the first dropped bit, bias the exponent
    function automatic logic [48:0] fp_pack(input logic s, input logic signed [13:0] e,
                                            input logic [73:0] m);
        logic [6:0]         p;
        logic [73:0]        n;
        logic [36:0]        c;
        logic signed [13:0] x;
        p = 7'h00;
        for (int i = 0; i < 74; i++) begin
            if (m[i]) p = 7'(i);
        end
        n = m << (7'h49 - p);
        c = {1'b0, n[73:38]} + {36'h000000000, n[37]};
        x = e + 14'(p) - 14'sh0047;
        if (c[36]) begin
            c = {2'b01, 35'h000000000};
            x = x + 14'sh0001;
        end
        if (m == 74'h0) return 49'h0;
        return {(x > mdf_pkg::MDF_EXP_LIM) || (x < -mdf_pkg::MDF_EXP_LIM), s,
                11'(x + mdf_pkg::MDF_EXP_BIAS), c[35:0]};
    endfunction

    // unpack both floating operands
    wire [47:0]        fw_a = {acc.a, acc.q};
    wire [47:0]        fw_b = {op_hi, op_lo};
    wire               fa_s = fw_a[mdf_pkg::MDF_F_SIGN];
    wire               fb_s = fw_b[mdf_pkg::MDF_F_SIGN] ^ (cmd == mdf_pkg::MDF_OP_FSUB);
    wire signed [13:0] fa_e = 14'(fw_a[mdf_pkg::MDF_F_EXPHI:mdf_pkg::MDF_F_EXPLO])
                              - mdf_pkg::MDF_EXP_BIAS;
    wire signed [13:0] fb_e = 14'(fw_b[mdf_pkg::MDF_F_EXPHI:mdf_pkg::MDF_F_EXPLO])
                              - mdf_pkg::MDF_EXP_BIAS;
    wire [35:0]        fa_m = fw_a[35:0];
    wire [35:0]        fb_m = fw_b[35:0];

    // add and subtract: align the smaller, spill into the extension top
    wire               a_big = (fa_e >= fb_e);
    wire [13:0]        f_d   = a_big ? 14'(fa_e - fb_e) : 14'(fb_e - fa_e);
    wire [5:0]         f_sh  = (f_d > mdf_pkg::MDF_ALIGN_MAX) ? 6'h3F : f_d[5:0];
    wire [35:0]        big_m = a_big ? fa_m : fb_m;
    wire [35:0]        sml_m = a_big ? fb_m : fa_m;
    wire               big_s = a_big ? fa_s : fb_s;
    wire               sml_s = a_big ? fb_s : fa_s;
    wire [83:0]        f_al  = {sml_m, 48'h000000000000} >> f_sh;
    wire [73:0]        big74 = {2'b00, big_m, 36'h000000000};
    wire [73:0]        sml74 = {2'b00, f_al[83:48], 36'h000000000};
    wire               f_ge  = (big74 >= sml74);
    wire [73:0]        fs_m  = (big_s == sml_s) ? big74 + sml74 : f_ge ? big74 - sml74 : sml74 - big74;
    wire               fs_s  = ((big_s == sml_s) || f_ge) ? big_s : sml_s;
    wire [48:0]        fs_w  = fp_pack(fs_s, a_big ? fa_e : fb_e, fs_m);

    // multiply: 72-bit unnormalised product
    wire [71:0]        fm_p = fa_m * fb_m;
    wire [48:0]        fm_w = fp_pack(fa_s ^ fb_s, 14'(fa_e + fb_e), {2'b00, fm_p});

    // divide: coefficient quotient scaled by 2**72, remainder follows dividend sign
    wire               fd_f = !fb_m[35];
    wire [107:0]       fd_n = {fa_m, 72'h0};
    wire [107:0]       fd_d = fd_f ? 108'h1 : {72'h0, fb_m};
    wire [107:0]       fd_q = fd_n / fd_d;
    wire [107:0]       fd_r = fd_n % fd_d;
    wire [47:0]        fd_e = fa_s ? 48'(-{12'h000, fd_r[35:0]}) : {12'h000, fd_r[35:0]};
    wire [48:0]        fd_w = fp_pack(fa_s ^ fb_s, 14'(fa_e - fb_e), fd_q[73:0]);

    ////////////////////////////////////////////////////////////////////////
    // result selection for the execute cycle
    mdf_pkg::mdf_acc_t next_acc;
    logic              next_dvf;
    logic              next_exf;
    always_comb begin
        next_acc = acc;
        next_dvf = 1'b0;
        next_exf = 1'b0;
        unique case (cmd)
            mdf_pkg::MDF_OP_MUL_S: {next_acc.q, next_acc.a} = mu_p;
            mdf_pkg::MDF_OP_DIV_S: begin
                next_dvf = dv_f;
                if (!dv_f) {next_acc.a, next_acc.q} = {dv_q[23:0], dv_r[23:0]};
            end
            mdf_pkg::MDF_OP_MUL_D: {next_acc.a, next_acc.q, next_acc.e} = md_p;
            mdf_pkg::MDF_OP_DIV_D: begin
                next_dvf = dd_f;
                if (!dd_f) {next_acc.a, next_acc.q, next_acc.e} = {dd_q[47:0], dd_r[47:0]};
            end
            mdf_pkg::MDF_OP_FADD, mdf_pkg::MDF_OP_FSUB: begin
                {next_exf, next_acc.a, next_acc.q} = fs_w;
                next_acc.e = f_al[47:0];
            end
            mdf_pkg::MDF_OP_FMUL: begin
                {next_exf, next_acc.a, next_acc.q} = fm_w;
                next_acc.e = {fm_p[35:0], 12'h000};
            end
            default: begin
                next_dvf = fd_f;
                if (!fd_f) {next_exf, next_acc.a, next_acc.q} = fd_w;
                if (!fd_f) next_acc.e = fd_e;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: fetch one or two words, then execute in one cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= mdf_pkg::MDF_IDLE;
            cmd          <= 6'h00;
            op_hi        <= 24'h000000;
            op_lo        <= 24'h000000;
            mem_req      <= 1'b0;
            mem_addr     <= 15'h0000;
            acc          <= {mdf_pkg::MDF_ACC_RST, mdf_pkg::MDF_ACC_RST, mdf_pkg::MDF_EXT_RST};
            done         <= 1'b0;
            trap         <= 1'b0;
            divide_fault <= 1'b0;
            exp_fault    <= 1'b0;
        end else begin
            done         <= 1'b0;
            divide_fault <= 1'b0;
            exp_fault    <= 1'b0;
            trap         <= do_trap && (state == mdf_pkg::MDF_IDLE);
            unique case (state)
                mdf_pkg::MDF_IDLE: begin
                    if (acc_wr) acc <= acc_in;
                    if (do_go) begin
                        cmd      <= req.opcode;
                        mem_addr <= req.addr;
                        mem_req  <= 1'b1;
                        state    <= mdf_pkg::MDF_HI;
                    end
                end
                mdf_pkg::MDF_HI: begin
                    if (mem_ack) begin
                        op_hi    <= mem_rdata;
                        mem_addr <= mem_addr + 15'h0001;
                        mem_req  <= cmd_two;
                        state    <= cmd_two ? mdf_pkg::MDF_LO : mdf_pkg::MDF_EXEC;
                    end
                end
                mdf_pkg::MDF_LO: begin
                    if (mem_ack) begin
                        op_lo   <= mem_rdata;
                        mem_req <= 1'b0;
                        state   <= mdf_pkg::MDF_EXEC;
                    end
                end
                mdf_pkg::MDF_EXEC: begin
                    acc          <= next_acc;
                    done         <= 1'b1;
                    divide_fault <= next_dvf;
                    exp_fault    <= next_exf && !next_dvf;
                    state        <= mdf_pkg::MDF_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dflt @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // switch gating: a trapped operation touches nothing else
    trap_no_fetch_a: assert property ($rose(trap)
        |-> !mem_req && state == mdf_pkg::MDF_IDLE)
        else $error("trapped operation started a fetch");
    trap_gate_a: assert property (start && is_two && !sw_s2
        && state == mdf_pkg::MDF_IDLE |=> trap)
        else $error("gated operation not trapped");
    trap_quiet_a: assert property (trap |-> !done && !mem_req)
        else $error("trap came with done or a fetch");

    // operand fetch: request held until answered, words at M then M+1
    hold_req_a: assert property (mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr))
        else $error("fetch request dropped before answer");
    first_word_a: assert property ($rose(mem_req)
        |-> mem_addr == $past(req.addr))
        else $error("first word not at effective address");
    second_word_a: assert property (state == mdf_pkg::MDF_HI && mem_ack && cmd_two
        |=> mem_req && mem_addr == $past(mem_addr) + 15'h0001)
        else $error("second word address wrong");
    one_word_a: assert property (state == mdf_pkg::MDF_HI && mem_ack && !cmd_two
        |=> !mem_req && state == mdf_pkg::MDF_EXEC)
        else $error("single operand fetch did not stop");

    // fixed point results and range faults
    mul_single_a: assert property (done && cmd == mdf_pkg::MDF_OP_MUL_S
        |-> {acc.q, acc.a} == $past(mu_p))
        else $error("single product misplaced");
    div_single_a: assert property (done && cmd == mdf_pkg::MDF_OP_DIV_S
        && !divide_fault |-> acc.a == $past(dv_q[23:0]) && acc.q == $past(dv_r[23:0]))
        else $error("single quotient or remainder wrong");
    div_abort_a: assert property (state == mdf_pkg::MDF_EXEC
        && cmd == mdf_pkg::MDF_OP_DIV_S && dv_f |=> divide_fault && done)
        else $error("single overflow not flagged");
    mul_double_a: assert property (done && cmd == mdf_pkg::MDF_OP_MUL_D
        |-> {acc.a, acc.q, acc.e} == $past(md_p))
        else $error("double product misplaced");
    div_double_a: assert property (done && cmd == mdf_pkg::MDF_OP_DIV_D
        && !divide_fault |-> {acc.a, acc.q} == $past(dd_q[47:0])
        && acc.e == $past(dd_r[47:0]))
        else $error("double quotient or remainder wrong");
    div_range_a: assert property (state == mdf_pkg::MDF_EXEC
        && cmd == mdf_pkg::MDF_OP_DIV_D && dd_f |=> divide_fault && done)
        else $error("double overflow not flagged");

    // floating results, spill and exponent range
    fadd_sum_a: assert property (done && (cmd == mdf_pkg::MDF_OP_FADD
        || cmd == mdf_pkg::MDF_OP_FSUB) |-> {acc.a, acc.q} == $past(fs_w[47:0]))
        else $error("floating sum or difference wrong");
    align_spill_a: assert property (done && (cmd == mdf_pkg::MDF_OP_FADD
        || cmd == mdf_pkg::MDF_OP_FSUB) |-> acc.e == $past(f_al[47:0]))
        else $error("alignment spill not in extension");
    exp_range_a: assert property (state == mdf_pkg::MDF_EXEC && next_exf
        && !next_dvf |=> exp_fault && done)
        else $error("exponent range fault missing");
    fmul_prod_a: assert property (done && cmd == mdf_pkg::MDF_OP_FMUL
        |-> {acc.a, acc.q} == $past(fm_w[47:0]))
        else $error("floating product wrong");
    fmul_ext_a: assert property (done && cmd == mdf_pkg::MDF_OP_FMUL
        |-> acc.e[47:12] == $past(fm_p[35:0]) && acc.e[11:0] == 12'h000)
        else $error("extension product bits wrong");
    fdiv_quot_a: assert property (done && cmd == mdf_pkg::MDF_OP_FDIV
        && !divide_fault |-> {acc.a, acc.q} == $past(fd_w[47:0]) && acc.e == $past(fd_e))
        else $error("floating quotient or remainder wrong");
    fdiv_rem_a: assert property (done && cmd == mdf_pkg::MDF_OP_FDIV
        && !divide_fault |-> (acc.e == 48'h000000000000) || (acc.e[47] == $past(fa_s)))
        else $error("remainder sign differs from dividend");
    fdiv_norm_a: assert property (state == mdf_pkg::MDF_EXEC
        && cmd == mdf_pkg::MDF_OP_FDIV && !fb_m[35] |=> divide_fault)
        else $error("unnormalized divisor not flagged");

    // fault pulses travel with completion
    fault_pulse_a: assert property ($rose(divide_fault) || $rose(exp_fault)
        |-> done ##1 !divide_fault && !exp_fault)
        else $error("fault not a single pulse with done");
    fault_done_a: assert property (divide_fault || exp_fault |-> done)
        else $error("fault without completion");
endmodule
`default_nettype wire

// ==== sim/mdf_store_model.sv ====
// storage side model: answers each read of the unit after lat idle cycles
// assumes the unit holds mem_req and mem_addr steady until mem_ack
`default_nettype none
module mdf_store_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        mem_req,
    input  wire logic [14:0] mem_addr,
    input  wire logic [1:0]  lat,
    output var  logic        mem_ack,
    output var  logic [23:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] mem [0:31];
    logic [1:0]  wait_cnt;
    ////////////////////////////////////////////////////////////////////////
    // data off the ack cycle inverts each cycle, so a sample one cycle late never matches
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 24'h000000;
            wait_cnt  <= 2'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= lat) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr[4:0]];
            wait_cnt  <= 2'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/mdf_unit_bench.sv ====
// self-checking bench for the multiply, divide and floating datapath
// assumes the storage model answers every read the unit makes
`default_nettype none
module mdf_unit_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ctl holds check select (0 all, 1 e only, 2 none) over the fault pair
    typedef struct packed {
        logic [5:0]  op;
        logic [3:0]  ctl;
        logic [23:0] ia;
        logic [23:0] iq;
        logic [47:0] ie;
        logic [47:0] w;
        logic [23:0] xa;
        logic [23:0] xq;
        logic [47:0] xe;
    } mdf_row_t;
    logic               sys_clk, sys_rst, start, float_enable_switch, acc_wr;
    logic               mem_req, mem_ack, done, trap, divide_fault, exp_fault;
    logic [14:0]        mem_addr;
    logic [23:0]        mem_rdata;
    logic [1:0]         lat;
    mdf_pkg::mdf_req_t  req;
    mdf_pkg::mdf_acc_t  acc_in;
    mdf_pkg::mdf_acc_t  acc;
    int                 n_fail;
    int                 checked;
    logic [5:0]         gated [6] = '{6'h2E, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33};
    mdf_row_t           rows [15] = '{
        '{6'h28,4'h0,24'h3,24'h0,48'h0,48'hFFFFFE000000,
          24'hFFFFFA,24'hFFFFFF,48'h0},
        '{6'h29,4'h0,24'h0,24'h64,48'h0,48'h000007000000,24'hE,24'h2,48'h0},
        '{6'h29,4'h0,24'hFFFFFF,24'hFFFF9C,48'h0,48'h000007000000,
          24'hFFFFF2,24'hFFFFFE,48'h0},
        '{6'h29,4'hA,24'h1,24'h0,48'h0,48'h000001000000,24'h0,24'h0,48'h0},
        '{6'h2E,4'h0,24'h1,24'h0,48'h5,48'h000001000000,24'h0,24'h1,48'h0},
        '{6'h2F,4'h0,24'h0,24'h0,48'h64,48'h7,24'h0,24'hE,48'h2},
        '{6'h2F,4'hA,24'h0,24'h1,48'h0,48'h1,24'h0,24'h0,48'h0},
        '{6'h30,4'h0,24'h400800,24'h0,48'h0,48'h400800000000,
          24'h401800,24'h0,48'h0},
        '{6'h30,4'h4,24'h401800,24'h0,48'h0,48'h400800000001,
          24'h0,24'h0,48'h800000000000},
        '{6'h31,4'h0,24'h401800,24'h0,48'h0,48'h400800000000,
          24'h400800,24'h0,48'h0},
        '{6'h32,4'h0,24'h400800,24'h1,48'h0,48'h400800000000,
          24'h3FF800,24'h1,48'h800000000000},
        '{6'h32,4'h9,24'h7FF800,24'h0,48'h0,48'h7FF800000000,24'h0,24'h0,48'h0},
        '{6'h33,4'hA,24'h400800,24'h0,48'h0,48'h400000000001,24'h0,24'h0,48'h0},
        '{6'h33,4'h4,24'hC00800,24'h0,48'h0,48'h400C00000000,
          24'h0,24'h0,48'hFFF800000000},
        '{6'h32,4'h9,24'h001800,24'h0,48'h0,48'h001800000000,24'h0,24'h0,48'h0}
    };
    ////////////////////////////////////////////////////////////////////////
    mdf_unit mdf_unit_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .req(req),
        .float_enable_switch(float_enable_switch), .acc_wr(acc_wr), .acc_in(acc_in),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .acc(acc), .done(done), .trap(trap), .divide_fault(divide_fault),
        .exp_fault(exp_fault));
    mdf_store_model mdf_store_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // entered at a falling edge; loads accumulators, starts, waits for done
    task automatic run_op(input mdf_row_t r, input logic [14:0] m);
        logic [95:0] mask;
        int          k;
        mask = (r.ctl[3:2] == 2'h0) ? {96{1'b1}} :
               (r.ctl[3:2] == 2'h1) ? {48'h0, {48{1'b1}}} : 96'h0;
        mdf_store_model_inst.mem[m[4:0]] = r.w[47:24];
        mdf_store_model_inst.mem[m[4:0] + 5'h01] = r.w[23:0];
        acc_in = {r.ia, r.iq, r.ie};
        acc_wr = 1'b1;
        @(negedge sys_clk);
        acc_wr = 1'b0;
        req = {r.op, m};
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        check(done === 1'b1 && divide_fault === r.ctl[1] && exp_fault === r.ctl[0], "flags");
        check(((acc ^ {r.xa, r.xq, r.xe}) & mask) === 96'h0, "accumulators");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // whole run is some 180 cycles; 5000 means a hang
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        req = '0;
        float_enable_switch = 1'b1;
        acc_wr = 1'b0;
        acc_in = '0;
        lat = 2'h0;
        n_fail = 0;
        checked = 0;
        repeat (4) @(negedge sys_clk);
        check(acc === 96'h0 && done === 1'b0 && mem_req === 1'b0, "reset state");
        sys_rst = 1'b0;
        // switch synchroniser needs two edges before gated ops run
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < 15; i++) begin
            lat = 2'(i % 3);
            run_op(rows[i], (i == 4) ? 15'h7FFF : 15'(i * 3));
        end
        // a start while busy is dropped without trace
        lat = 2'h3;
        fork
            run_op(rows[0], 15'h0040);
            begin
                repeat (3) @(negedge sys_clk);
                req = {6'h29, 15'h0041};
                start = 1'b1;
                @(negedge sys_clk);
                start = 1'b0;
            end
        join
        repeat (10) begin
            @(negedge sys_clk);
            check(done === 1'b0, "start while busy ran");
        end
        float_enable_switch = 1'b0;
        repeat (3) @(negedge sys_clk);
        foreach (gated[j]) begin
            req = {gated[j], 15'h0005};
            start = 1'b1;
            @(negedge sys_clk);
            start = 1'b0;
            check(trap === 1'b1 && done === 1'b0 && mem_req === 1'b0, "no trap");
            @(negedge sys_clk);
            check(trap === 1'b0 && done === 1'b0 && mem_req === 1'b0, "trap held");
            @(negedge sys_clk);
        end
        run_op(rows[0], 15'h0009);
        complete_run();
    end
endmodule
`default_nettype wire
